// >>> pdm_top.sv
/*
 * Power-down mode control: standby select, module clock stops,
 * sleep/standby sequencing and the processing-state pins.
 * Assumes reset and sleep/wake inputs synchronous to aclk, and an
 * AXI4-Lite master that keeps to one write and one read at a time.
 */
// How it works
// R1: State pins: 11 manual, 10 sleep, 01 standby.
// R2: Low power-on input starts power-on reset.
// R3: Low manual input starts manual reset.
// R4: State pins driven only when mux selects.
// R5: Standby select clears on power-on or bus reset only.
// R6: Standby registers take byte writes only.
// R7: Select bit 7 picks sleep or standby.
// R8: Select bits 6..0 read zero.
// R9: Clock-stop register clears on power-on or bus reset only.
// R10: Clock-stop bit 3 reserved, reads zero.
// R11: Bit 7 stops debug interface clock.
// R12: Bit 6 stops break controller clock.
// R13: Bit 5 stops DMA clock.
// R14: Bit 4 stops DSP clock.
// R15: Bit 2 stops cache clock.
// R16: Bit 1 stops U memory clock.
// R17: Bit 0 stops X/Y memory clock.
// R18: Sleep halts processor; standby halts generator too.
// R19: Interrupt or reset ends sleep and standby.
// R20: Manual-reset code wins over low-power codes.
`timescale 1ns/10ps
module pdm_top
   import pdm_pkg::*;
#(
   parameter int ADDR_W = 4
)
(
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic                poweron_rst_n,
   input  wire logic                manual_rst_n,
   input  wire logic                sleep_exec,
   input  wire logic                wake_irq,
   input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [ADDR_W-1:0]   s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   output logic                     standby_select,
   output pdm_clk_stop_t            clk_stop,
   output logic                     cpu_halt,
   output logic                     cpg_halt,
   output logic                     por_active,
   output logic                     manual_active,
   output logic                     proc_state_code_hi,
   output logic                     proc_state_code_lo,
   output logic                     proc_state_oe
);

   // ----------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------
   if (ADDR_W < 4)
   begin : g_bad_addr
      $error("pdm_top: ADDR_W must be at least 4");
   end

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic                por_clear;
   logic [7:0]          standby_select_sel_q;
   logic [7:0]          clk_stop_q;
   logic [7:0]          pin_mux_q;
   pdm_mode_t           mode_q;
   pdm_mode_t           mode_d;
   logic [1:0]          code_q;
   logic [1:0]          code_d;
   logic                aw_held_q;
   logic [ADDR_W-1:0]   aw_addr_q;
   logic                w_held_q;
   logic [7:0]          w_byte_q;
   logic [3:0]          w_strb_q;
   logic                bvalid_q;
   logic [1:0]          bresp_q;
   logic                rvalid_q;
   logic [31:0]         rdata_q;
   logic [1:0]          rresp_q;
   logic                wr_fire;
   logic [3:0]          wr_ofs;
   logic [3:0]          rd_ofs;
   logic                wr_byte_ok;
   logic                wr_mapped;
   logic                rd_mapped;
   logic [7:0]          rd_byte;

   // ----------------------------------------------------------------
   // Reset sources
   // ----------------------------------------------------------------
   // Bus reset and the power-on pin both clear registers, mode and pins; bus channels clear on bus reset only.
   assign por_clear     = !aresetn || !poweron_rst_n;   // R2
   assign por_active    = !poweron_rst_n;               // R2
   assign manual_active = !manual_rst_n;                // R3

   // ----------------------------------------------------------------
   // Write channel
   // ----------------------------------------------------------------
   assign s_axi_awready = !aw_held_q && !bvalid_q;
   assign s_axi_wready  = !w_held_q && !bvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign wr_fire       = aw_held_q && w_held_q && !bvalid_q;
   assign wr_ofs        = aw_addr_q[3:0];
   assign wr_byte_ok    = (w_strb_q == PDM_BYTE_STRB);   // R6
   assign wr_mapped     = ((aw_addr_q >> 4) == '0) &&
                          ((wr_ofs == PDM_OFS_STANDBY_SELECT_SEL) ||
                           (wr_ofs == PDM_OFS_CLK_STOP) ||
                           (wr_ofs == PDM_OFS_PIN_MUX));

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_q <= 1'b0;
         aw_addr_q <= '0;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_held_q <= 1'b1;
         aw_addr_q <= s_axi_awaddr;
      end
      else if (wr_fire)
      begin
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held_q <= 1'b0;
         w_byte_q <= 8'h00;
         w_strb_q <= 4'h0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_held_q <= 1'b1;
         w_byte_q <= s_axi_wdata[7:0];
         w_strb_q <= s_axi_wstrb;
      end
      else if (wr_fire)
      begin
         w_held_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_q <= 1'b0;
         bresp_q  <= PDM_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid_q <= 1'b1;
         // Wider or misplaced writes are refused, not half applied
         bresp_q  <= (wr_mapped && wr_byte_ok) ? PDM_RESP_OKAY
                                                : PDM_RESP_SLVERR; // R6
      end
      else if (s_axi_bready)
      begin
         bvalid_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Manual reset leaves these alone; only power-on or bus reset clears them.
   always_ff @(posedge aclk)
   begin
      if (por_clear)
      begin
         standby_select_sel_q <= PDM_STANDBY_SELECT_SEL_RST;                 // R5
      end
      else if (wr_fire && wr_byte_ok && wr_mapped &&
               (wr_ofs == PDM_OFS_STANDBY_SELECT_SEL))
      begin
         standby_select_sel_q <= w_byte_q & PDM_STANDBY_SELECT_MASK;         // R6 R8
      end
   end

   always_ff @(posedge aclk)
   begin
      if (por_clear)
      begin
         clk_stop_q <= PDM_CLK_STOP_RST;                 // R9
      end
      else if (wr_fire && wr_byte_ok && wr_mapped &&
               (wr_ofs == PDM_OFS_CLK_STOP))
      begin
         clk_stop_q <= w_byte_q & PDM_CLK_STOP_MASK;     // R6 R10
      end
   end

   always_ff @(posedge aclk)
   begin
      if (por_clear)
      begin
         pin_mux_q <= PDM_PIN_MUX_RST;
      end
      else if (wr_fire && wr_byte_ok && wr_mapped &&
               (wr_ofs == PDM_OFS_PIN_MUX))
      begin
         pin_mux_q <= w_byte_q & PDM_PIN_MUX_MASK;
      end
   end

   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
   assign rd_ofs        = s_axi_araddr[3:0];
   assign rd_mapped     = ((s_axi_araddr >> 4) == '0) &&
                          ((rd_ofs == PDM_OFS_STANDBY_SELECT_SEL) ||
                           (rd_ofs == PDM_OFS_CLK_STOP) ||
                           (rd_ofs == PDM_OFS_STATE) ||
                           (rd_ofs == PDM_OFS_PIN_MUX));

   always_comb
   begin
      unique case (rd_ofs)
         PDM_OFS_STANDBY_SELECT_SEL: rd_byte = standby_select_sel_q & PDM_STANDBY_SELECT_MASK;  // R8
         PDM_OFS_CLK_STOP: rd_byte = clk_stop_q & PDM_CLK_STOP_MASK; // R10
         PDM_OFS_STATE:    rd_byte = {6'b00_0000, code_q};
         PDM_OFS_PIN_MUX:  rd_byte = pin_mux_q;
         default:          rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= PDM_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_mapped ? {24'h00_0000, rd_byte} : 32'h0000_0000;
         rresp_q  <= rd_mapped ? PDM_RESP_OKAY : PDM_RESP_SLVERR;
      end
      else if (s_axi_rready)
      begin
         rvalid_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Low-power sequencing
   // ----------------------------------------------------------------
   always_comb
   begin
      mode_d = mode_q;
      unique case (mode_q)
         PDM_RUN:
         begin
            if (sleep_exec && !wake_irq)
            begin
               mode_d = standby_select_sel_q[PDM_BIT_STANDBY_SELECT] ? PDM_STANDBY
                                                 : PDM_SLEEP;  // R7
            end
         end
         PDM_SLEEP,
         PDM_STANDBY:
         begin
            if (wake_irq)
            begin
               mode_d = PDM_RUN;                               // R19
            end
         end
         default: mode_d = PDM_RUN;
      endcase
   end

   // Either reset drops straight back to normal operation.
   always_ff @(posedge aclk)
   begin
      if (por_clear || !manual_rst_n)
      begin
         mode_q <= PDM_RUN;                                    // R19
      end
      else
      begin
         mode_q <= mode_d;
      end
   end

   assign standby_select = standby_select_sel_q[PDM_BIT_STANDBY_SELECT];           // R7
   assign cpu_halt       = (mode_q != PDM_RUN);                // R18
   assign cpg_halt       = (mode_q == PDM_STANDBY);            // R18

   // ----------------------------------------------------------------
   // Module clock stops
   // ----------------------------------------------------------------
   // Standby halts every peripheral; sleep halts the breaker, cache, U and X/Y memory.
   always_ff @(posedge aclk)
   begin
      if (por_clear)
      begin
         clk_stop <= '0;
      end
      else
      begin
         clk_stop.debug_if_clk_stop  <= clk_stop_q[PDM_BIT_DEBUG_IF] ||
                                        cpg_halt;              // R11
         clk_stop.break_ctl_clk_stop <= clk_stop_q[PDM_BIT_BREAK] ||
                                        cpu_halt;              // R12
         clk_stop.dma_clk_stop       <= clk_stop_q[PDM_BIT_DMA] ||
                                        cpg_halt;              // R13
         clk_stop.dsp_clk_stop       <= clk_stop_q[PDM_BIT_DSP] ||
                                        cpg_halt;              // R14
         clk_stop.cache_clk_stop     <= clk_stop_q[PDM_BIT_CACHE] ||
                                        cpu_halt;              // R15
         clk_stop.umem_clk_stop      <= clk_stop_q[PDM_BIT_UMEM] ||
                                        cpu_halt;              // R16
         clk_stop.xymem_clk_stop     <= clk_stop_q[PDM_BIT_XYMEM] ||
                                        cpu_halt;              // R17
      end
   end

   // ----------------------------------------------------------------
   // Processing-state pins
   // ----------------------------------------------------------------
   always_comb
   begin
      if (!manual_rst_n)
      begin
         code_d = PDM_CODE_MANUAL;                             // R1 R20
      end
      else if (mode_q == PDM_SLEEP)
      begin
         code_d = PDM_CODE_SLEEP;                              // R1
      end
      else if (mode_q == PDM_STANDBY)
      begin
         code_d = PDM_CODE_STANDBY;                            // R1
      end
      else
      begin
         code_d = PDM_CODE_NORMAL;                             // R1
      end
   end

   always_ff @(posedge aclk)
   begin
      if (por_clear)
      begin
         code_q <= PDM_CODE_NORMAL;
      end
      else
      begin
         code_q <= code_d;
      end
   end

   // Pins idle low and undriven unless the mux hands them over.
   assign proc_state_oe      = pin_mux_q[PDM_BIT_PIN_EN];      // R4
   assign proc_state_code_hi = proc_state_oe & code_q[1];      // R4
   assign proc_state_code_lo = proc_state_oe & code_q[0];      // R4

endmodule : pdm_top

// >>> pdm_pkg.sv
/*
 * Shared constants and types of the power-down mode control block:
 * register offsets, field positions, reset values, state codes.
 * Assumes a 32-bit AXI4-Lite register bus with byte-wide registers.
 */
package pdm_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [3:0] PDM_OFS_STANDBY_SELECT_SEL  = 4'h0;
   localparam logic [3:0] PDM_OFS_CLK_STOP  = 4'h4;
   localparam logic [3:0] PDM_OFS_STATE     = 4'h8;
   localparam logic [3:0] PDM_OFS_PIN_MUX   = 4'hC;

   localparam logic [7:0] PDM_STANDBY_SELECT_SEL_RST  = 8'h00;
   localparam logic [7:0] PDM_CLK_STOP_RST  = 8'h00;
   localparam logic [7:0] PDM_PIN_MUX_RST   = 8'h00;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int         PDM_BIT_STANDBY_SELECT      = 7;
   localparam int         PDM_BIT_DEBUG_IF  = 7;
   localparam int         PDM_BIT_BREAK     = 6;
   localparam int         PDM_BIT_DMA       = 5;
   localparam int         PDM_BIT_DSP       = 4;
   localparam int         PDM_BIT_RSVD      = 3;
   localparam int         PDM_BIT_CACHE     = 2;
   localparam int         PDM_BIT_UMEM      = 1;
   localparam int         PDM_BIT_XYMEM     = 0;
   localparam int         PDM_BIT_PIN_EN    = 0;
   localparam logic [7:0] PDM_CLK_STOP_MASK = 8'hF7;
   localparam logic [7:0] PDM_STANDBY_SELECT_MASK     = 8'h80;
   localparam logic [7:0] PDM_PIN_MUX_MASK  = 8'h01;

   // ----------------------------------------------------------------
   // Bus answers and byte lane
   // ----------------------------------------------------------------
   localparam logic [1:0] PDM_RESP_OKAY     = 2'b00;
   localparam logic [1:0] PDM_RESP_SLVERR   = 2'b10;
   localparam logic [3:0] PDM_BYTE_STRB     = 4'b0001;

   // ----------------------------------------------------------------
   // Processing-state codes, high bit first
   // ----------------------------------------------------------------
   localparam logic [1:0] PDM_CODE_MANUAL   = 2'b11;
   localparam logic [1:0] PDM_CODE_SLEEP    = 2'b10;
   localparam logic [1:0] PDM_CODE_STANDBY  = 2'b01;
   localparam logic [1:0] PDM_CODE_NORMAL   = 2'b00;

   typedef enum logic [1:0] {
      PDM_RUN,
      PDM_SLEEP,
      PDM_STANDBY
   } pdm_mode_t;

   typedef struct packed {
      logic debug_if_clk_stop;
      logic break_ctl_clk_stop;
      logic dma_clk_stop;
      logic dsp_clk_stop;
      logic cache_clk_stop;
      logic umem_clk_stop;
      logic xymem_clk_stop;
   } pdm_clk_stop_t;

endpackage : pdm_pkg

// >>> pdm_props.sv
/*
 * Port checker for the power-down mode control block.
 * Assumes a bind onto pdm_top and one clock domain, aclk.
 */
`timescale 1ns/10ps
module pdm_props
   import pdm_pkg::*;
(
   input wire logic           aclk,
   input wire logic           aresetn,
   input wire logic           poweron_rst_n,
   input wire logic           manual_rst_n,
   input wire logic           sleep_exec,
   input wire logic           wake_irq,
   input wire logic           standby_select,
   input wire pdm_clk_stop_t  clk_stop,
   input wire logic           cpu_halt,
   input wire logic           cpg_halt,
   input wire logic           por_active,
   input wire logic           manual_active,
   input wire logic           proc_state_code_hi,
   input wire logic           proc_state_code_lo,
   input wire logic           proc_state_oe
);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_rst_flags;
      por_active == !poweron_rst_n && manual_active == !manual_rst_n;
   endproperty
   a_rst_flags: assert property (p_rst_flags)
      else $error("reset flags do not follow reset inputs");
   property p_pin_off;
      !proc_state_oe |-> !proc_state_code_hi && !proc_state_code_lo;
   endproperty
   a_pin_off: assert property (p_pin_off)
      else $error("state pins driven while mux clear");
   // Code lags the mode by one edge, so compare against last mode
   property p_code;
      poweron_rst_n && manual_rst_n ##1 proc_state_oe |->
         {proc_state_code_hi, proc_state_code_lo} ==
         {$past(cpu_halt) && !$past(cpg_halt), $past(cpg_halt)};
   endproperty
   a_code: assert property (p_code)
      else $error("state code does not match mode");
   property p_manual;
      !manual_rst_n && poweron_rst_n ##1 proc_state_oe |->
         {proc_state_code_hi, proc_state_code_lo} == PDM_CODE_MANUAL;
   endproperty
   a_manual: assert property (p_manual)
      else $error("manual reset code not shown");
   property p_enter;
      sleep_exec && !cpu_halt && !wake_irq && poweron_rst_n
         && manual_rst_n |=> cpu_halt && cpg_halt == $past(standby_select);
   endproperty
   a_enter: assert property (p_enter)
      else $error("sleep entry picked the wrong mode");
   property p_wake;
      (wake_irq || !manual_rst_n) && cpu_halt |=> !cpu_halt;
   endproperty
   a_wake: assert property (p_wake)
      else $error("low-power mode not left");
   property p_nest;
      cpg_halt |-> cpu_halt;
   endproperty
   a_nest: assert property (p_nest)
      else $error("generator halted with processor running");
   property p_standby_select_stops;
      cpg_halt && $past(cpg_halt) |-> clk_stop == 7'h7F;
   endproperty
   a_standby_select_stops: assert property (p_standby_select_stops)
      else $error("standby left a module clock running");
   property p_por_clear;
      !poweron_rst_n |=> !standby_select && clk_stop == 7'h00
         && !cpu_halt && !proc_state_oe;
   endproperty
   a_por_clear: assert property (p_por_clear)
      else $error("power-on reset did not clear state");

   c_sleep: cover property (cpu_halt && !cpg_halt);
   c_standby_select: cover property (cpg_halt);
   c_man_halt: cover property (!manual_rst_n && $past(cpu_halt));
endmodule : pdm_props

// >>> pdm_ext_model.sv
/*
 * Board-side model: reset sources and a state-pin monitor.
 * Assumes requests from the bench and pins from pdm_top.
 */
`timescale 1ns/10ps
module pdm_ext_model
(
   input  wire logic        aclk,
   input  wire logic        por_req,
   input  wire logic        man_req,
   output logic             poweron_rst_n,
   output logic             manual_rst_n,
   input  wire logic        code_hi,
   input  wire logic        code_lo,
   input  wire logic        code_oe,
   output logic [1:0]       pin_code
);
   logic [1:0] last_q = 2'b00;

   // ----------------------------------------------------------------
   // Reset drive, synchronous to aclk
   // ----------------------------------------------------------------
   always @(posedge aclk)
   begin
      poweron_rst_n <= !por_req;
      manual_rst_n <= !man_req;
      if (code_oe)
         last_q <= {code_hi, code_lo};
   end
   // Released pins float: show the inverse so no stale code passes
   assign pin_code = code_oe ? {code_hi, code_lo} : ~last_q;
endmodule : pdm_ext_model

// >>> power_down_mode_control_bench.sv
/*
 * Self-checking bench for the power-down mode control block.
 * Assumes pdm_pkg, pdm_top, pdm_props and pdm_ext_model compiled.
 */
`timescale 1ns/10ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
bad_count++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module power_down_mode_control_bench
   import pdm_pkg::*;
;
   logic aclk = 1'b0, aresetn = 1'b0, sleep_exec = 1'b0, wake_irq = 1'b0;
   logic por_req = 1'b0, man_req = 1'b0, s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, d;
   logic [6:0] exp_stop;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, standby_select, cpu_halt, cpg_halt, por_active;
   logic manual_active, proc_state_code_hi, proc_state_code_lo;
   logic proc_state_oe, poweron_rst_n, manual_rst_n;
   logic [1:0] s_axi_bresp, s_axi_rresp, pin_code;
   pdm_clk_stop_t clk_stop;
   int bad_count = 0, comparisons = 0, cyc = 0;

   always #2.5 aclk = ~aclk;

   pdm_top #(.ADDR_W(4)) uut (.aclk, .aresetn, .poweron_rst_n,
      .manual_rst_n, .sleep_exec, .wake_irq, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .standby_select,
      .clk_stop, .cpu_halt, .cpg_halt, .por_active, .manual_active,
      .proc_state_code_hi, .proc_state_code_lo, .proc_state_oe);
   pdm_ext_model board (.aclk, .por_req, .man_req, .poweron_rst_n,
      .manual_rst_n, .code_hi(proc_state_code_hi),
      .code_lo(proc_state_code_lo), .code_oe(proc_state_oe), .pin_code);

   // ----------------------------------------------------------------
   // Bus and stimulus tasks
   // ----------------------------------------------------------------
   task automatic wr(input logic [3:0] a, input logic [31:0] v,
      input logic [3:0] s, input logic [1:0] er);
      logic ta, tw, ra, rw;
      ta = 1'b0;
      tw = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ta && tw))
      begin
         @(negedge aclk);
         ra = s_axi_awready & s_axi_awvalid;
         rw = s_axi_wready & s_axi_wvalid;
         @(posedge aclk);
         if (ra)
            s_axi_awvalid <= 1'b0;
         if (rw)
            s_axi_wvalid <= 1'b0;
         ta = ta | ra;
         tw = tw | rw;
      end
      while (s_axi_bvalid !== 1'b1)
         @(negedge aclk);
      `CHK("bresp", er, s_axi_bresp)
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [31:0] ev,
      input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(negedge aclk); while (s_axi_arready !== 1'b1);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
      `CHK("rdata", ev, s_axi_rdata)
      `CHK("rresp", er, s_axi_rresp)
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask : rd

   task automatic settle(input int n);
      repeat (n) @(posedge aclk);
      @(negedge aclk);
   endtask : settle

   // One-cycle pulse on wake or on sleep, then wait for the code
   task automatic kick(input bit w);
      @(posedge aclk);
      if (w)
         wake_irq <= 1'b1;
      else
         sleep_exec <= 1'b1;
      @(posedge aclk);
      wake_irq <= 1'b0;
      sleep_exec <= 1'b0;
      settle(1);
   endtask : kick

   task automatic wrap_up;
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : wrap_up

   // Generous ceiling: the sequence needs about 160 cycles
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 4000)
      begin
         bad_count++;
         wrap_up();
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rd(PDM_OFS_STANDBY_SELECT_SEL, 32'h0000_0000, PDM_RESP_OKAY);
      rd(PDM_OFS_CLK_STOP, 32'h0000_0000, PDM_RESP_OKAY);
      `CHK("oe", 1'b0, proc_state_oe)
      for (int i = 0; i < 8; i++)
      begin
         d = 32'h0000_0001 << i;
         wr(PDM_OFS_CLK_STOP, d, PDM_BYTE_STRB, PDM_RESP_OKAY);
         rd(PDM_OFS_CLK_STOP, d & 32'h0000_00F7, PDM_RESP_OKAY);
         exp_stop = (i == 3) ? 7'h00 : (i > 3) ? 7'h01 << (i - 1)
                                              : 7'h01 << i;
         `CHK("clk_stop", exp_stop, clk_stop)
      end
      wr(PDM_OFS_STANDBY_SELECT_SEL, 32'h0000_00FF, PDM_BYTE_STRB, PDM_RESP_OKAY);
      rd(PDM_OFS_STANDBY_SELECT_SEL, 32'h0000_0080, PDM_RESP_OKAY);
      `CHK("standby_select", 1'b1, standby_select)
      wr(PDM_OFS_STANDBY_SELECT_SEL, 32'h0000_0000, 4'hF, PDM_RESP_SLVERR);
      wr(PDM_OFS_CLK_STOP, 32'h0000_0000, 4'h2, PDM_RESP_SLVERR);
      rd(PDM_OFS_STANDBY_SELECT_SEL, 32'h0000_0080, PDM_RESP_OKAY);
      rd(PDM_OFS_CLK_STOP, 32'h0000_0080, PDM_RESP_OKAY);
      wr(4'h2, 32'h0000_0000, PDM_BYTE_STRB, PDM_RESP_SLVERR);
      rd(4'h2, 32'h0000_0000, PDM_RESP_SLVERR);
      wr(PDM_OFS_STANDBY_SELECT_SEL, 32'h0000_0000, PDM_BYTE_STRB, PDM_RESP_OKAY);
      wr(PDM_OFS_CLK_STOP, 32'h0000_0000, PDM_BYTE_STRB, PDM_RESP_OKAY);
      wr(PDM_OFS_PIN_MUX, 32'h0000_0001, PDM_BYTE_STRB, PDM_RESP_OKAY);
      `CHK("pins", 2'b00, pin_code)
      kick(1'b0);
      `CHK("halt", 2'b10, {cpu_halt, cpg_halt})
      `CHK("pins", 2'b10, pin_code)
      `CHK("clk_stop", 7'h27, clk_stop)
      rd(PDM_OFS_STATE, 32'h0000_0002, PDM_RESP_OKAY);
      kick(1'b1);
      `CHK("halt", 2'b00, {cpu_halt, cpg_halt})
      `CHK("pins", 2'b00, pin_code)
      wr(PDM_OFS_STANDBY_SELECT_SEL, 32'h0000_0080, PDM_BYTE_STRB, PDM_RESP_OKAY);
      wr(PDM_OFS_CLK_STOP, 32'h0000_0012, PDM_BYTE_STRB, PDM_RESP_OKAY);
      kick(1'b0);
      `CHK("halt", 2'b11, {cpu_halt, cpg_halt})
      `CHK("pins", 2'b01, pin_code)
      `CHK("clk_stop", 7'h7F, clk_stop)
      @(posedge aclk);
      man_req <= 1'b1;
      settle(2);
      `CHK("manual_active", 1'b1, manual_active)
      `CHK("pins", 2'b11, pin_code)
      `CHK("cpu_halt", 1'b0, cpu_halt)
      rd(PDM_OFS_STATE, 32'h0000_0003, PDM_RESP_OKAY);
      rd(PDM_OFS_STANDBY_SELECT_SEL, 32'h0000_0080, PDM_RESP_OKAY);
      rd(PDM_OFS_CLK_STOP, 32'h0000_0012, PDM_RESP_OKAY);
      man_req <= 1'b0;
      settle(3);
      `CHK("pins", 2'b00, pin_code)
      @(posedge aclk);
      por_req <= 1'b1;
      settle(2);
      `CHK("por_active", 1'b1, por_active)
      @(posedge aclk);
      por_req <= 1'b0;
      settle(2);
      rd(PDM_OFS_STANDBY_SELECT_SEL, 32'h0000_0000, PDM_RESP_OKAY);
      rd(PDM_OFS_CLK_STOP, 32'h0000_0000, PDM_RESP_OKAY);
      `CHK("oe", 1'b0, proc_state_oe)
      wrap_up();
   end
endmodule : power_down_mode_control_bench

bind pdm_top pdm_props u_props (.aclk, .aresetn, .poweron_rst_n,
   .manual_rst_n, .sleep_exec, .wake_irq, .standby_select, .clk_stop,
   .cpu_halt, .cpg_halt, .por_active, .manual_active, .proc_state_code_hi,
   .proc_state_code_lo, .proc_state_oe);
